// File: core/mul_pkg.sv
// Purpose: Shared constants and carriers for the mixed-sign multiplier.
// Assumes: 16-bit working registers, 40-bit accumulators, APB register access.
// Notes: Byte addresses are word aligned.
package mul_pkg;
   localparam int DATA_W = 16;
   localparam int PROD_W = 32;
   localparam int ACC_W = 40;
   localparam int NREG = 16;
   localparam int LIT_W = 5;
   localparam int REG_IDX_W = 4;
   localparam int MODE_W = 3;
   localparam int ADDR_W = 16;

   // APB register map (byte addresses).
   localparam logic [7:0] OFS_INSTR = 8'h00;
   localparam logic [7:0] OFS_CORE_CTRL = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_ACC_LO_A = 8'h0C;
   localparam logic [7:0] OFS_ACC_HI_A = 8'h10;
   localparam logic [7:0] OFS_ACC_LO_B = 8'h14;
   localparam logic [7:0] OFS_ACC_HI_B = 8'h18;
   localparam logic [7:0] OFS_WREG_BASE = 8'h40;
   localparam logic [7:0] OFS_MEM_DATA = 8'h80;

   // Core control register fields.
   localparam int CTRL_FRAC_BIT = 0;
   localparam int CTRL_SIGN_LSB = 1;
   localparam logic [2:0] CTRL_RESET = 3'h0;

   // Status register: status_flags_register image and busy flag.
   localparam int STAT_BUSY_BIT = 16;
   localparam logic [15:0] FLAGS_RESET = 16'h0000;

   // Instruction word fields (24-bit word).
   localparam int IW_OPB_LSB = 16;
   localparam int IW_SRC_SIGN_BIT = 15;
   localparam int IW_BASE_LSB = 11;
   localparam int IW_DST_LSB = 7;
   localparam int IW_ACC_BIT = 7;
   localparam int IW_MODE_LSB = 4;
   localparam int IW_SRC_LSB = 0;
   localparam logic [7:0] OPB_MUL_UNS = 8'hB8;
   localparam logic [7:0] OPB_MUL_SGN = 8'hB9;
   localparam logic [3:0] DST_ACC_CODE = 4'h7;
   localparam logic [2:0] MODE_LIT_HI = 3'h3;

   // Source addressing modes.
   localparam logic [2:0] AM_DIRECT = 3'h0;
   localparam logic [2:0] AM_IND = 3'h1;
   localparam logic [2:0] AM_POSTDEC = 3'h2;
   localparam logic [2:0] AM_POSTINC = 3'h3;
   localparam logic [2:0] AM_PREDEC = 3'h4;
   localparam logic [2:0] AM_PREINC = 3'h5;
   localparam logic [15:0] PTR_STEP = 16'h0002;

   typedef struct packed {
      logic is_acc;
      logic acc_sel;
      logic base_signed;
      logic src_signed;
      logic use_lit;
      logic [REG_IDX_W-1:0] base_idx;
      logic [REG_IDX_W-1:0] dst_idx;
      logic [MODE_W-1:0] mode;
      logic [REG_IDX_W-1:0] src_idx;
      logic [LIT_W-1:0] lit;
      logic legal;
   } decode_s;
endpackage

// File: core/mul_signed_core.sv
// Purpose: Combinational 16x16 multiplier with per-operand sign control.
// Assumes: Operands already chosen by the caller.
// Notes: Fractional mode shifts the product left by one.
`timescale 1ns/10ps
module mul_signed_core (
   // Operands
   input wire logic [15:0] op_a,
   input wire logic [15:0] op_b,
   input wire logic a_signed,
   input wire logic b_signed,
   input wire logic frac,
   // Result
   output logic [31:0] product
);
   logic signed [16:0] a_ext;
   logic signed [16:0] b_ext;
   logic signed [33:0] full;

   always_comb begin
      a_ext = {a_signed & op_a[15], op_a};
      b_ext = {b_signed & op_b[15], op_b};
      full = 34'(a_ext) * 34'(b_ext);
      product = frac ? {full[30:0], 1'b0} : full[31:0];
   end
endmodule

// File: core/mixed_sign_multiplier.sv
// Purpose: Mixed-sign 16x16 multiply unit with register file and accumulators.
// Assumes: Instruction word and data word written over APB; one op at a time.
// Notes: Writing the instruction register starts execution; busy shows in status.
`timescale 1ns/10ps

module mixed_sign_multiplier #(
   parameter logic [15:0] PERIPH_LIMIT = 16'h0800
) (
   // APB slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Data memory read port
   output logic [15:0] mem_addr,
   output logic mem_rd,
   input wire logic [15:0] mem_rdata
);
   typedef enum logic [1:0] {S_IDLE, S_FETCH, S_WAIT, S_EXEC} state_e;

   state_e state_q, state_d;
   logic [15:0] wreg_q [mul_pkg::NREG];
   logic [15:0] wreg_d [mul_pkg::NREG];
   logic [39:0] acc_a_q, acc_a_d, acc_b_q, acc_b_d;
   logic [23:0] instr_q, instr_d;
   logic [2:0] ctrl_q, ctrl_d;
   logic [15:0] flags_q;
   logic [15:0] opb_q, opb_d;
   logic [15:0] mem_addr_q, mem_addr_d;
   logic mem_rd_q, mem_rd_d;
   logic [31:0] prdata_q, prdata_d;
   logic pready_q, pready_d;
   logic pslverr_q, pslverr_d;
   mul_pkg::decode_s dec;
   logic [31:0] product;
   logic a_sgn, b_sgn, frac;
   logic [15:0] ptr, ptr_new;
   logic setup, wr_acc;
   logic bus_wr_en, ptr_wr_en, prod_wr_en;

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign mem_addr = mem_addr_q;
   assign mem_rd = mem_rd_q;
   assign setup = psel & ~penable;
   assign wr_acc = psel & penable & pready_q & pwrite;

   // Instruction decode.
   always_comb begin
      logic [7:0] opb;
      opb = instr_q[mul_pkg::IW_OPB_LSB +: 8];
      dec = '0;
      dec.legal = (opb == mul_pkg::OPB_MUL_UNS) | (opb == mul_pkg::OPB_MUL_SGN);
      dec.base_signed = (opb == mul_pkg::OPB_MUL_SGN);
      dec.src_signed = instr_q[mul_pkg::IW_SRC_SIGN_BIT];
      dec.base_idx = instr_q[mul_pkg::IW_BASE_LSB +: 4];
      dec.dst_idx = instr_q[mul_pkg::IW_DST_LSB +: 4];
      dec.is_acc = (instr_q[mul_pkg::IW_DST_LSB + 1 +: 3] == mul_pkg::DST_ACC_CODE[2:0]);
      dec.acc_sel = instr_q[mul_pkg::IW_ACC_BIT];
      dec.mode = instr_q[mul_pkg::IW_MODE_LSB +: 3];
      dec.src_idx = instr_q[mul_pkg::IW_SRC_LSB +: 4];
      dec.use_lit = (instr_q[mul_pkg::IW_MODE_LSB + 1 +: 2] == mul_pkg::MODE_LIT_HI[1:0]);
      dec.lit = instr_q[mul_pkg::IW_SRC_LSB +: 5];
      if (dec.is_acc) begin
         dec.dst_idx = '0;
      end
      if (dec.use_lit) begin
         dec.mode = mul_pkg::AM_DIRECT;
      end
   end

   // Pointer arithmetic for indirect modes.
   always_comb begin
      ptr = wreg_q[dec.src_idx];
      case (dec.mode)
         mul_pkg::AM_POSTDEC, mul_pkg::AM_PREDEC: ptr_new = ptr - mul_pkg::PTR_STEP;
         mul_pkg::AM_POSTINC, mul_pkg::AM_PREINC: ptr_new = ptr + mul_pkg::PTR_STEP;
         default: ptr_new = ptr;
      endcase
   end

   // Register forms ignore the fractional control bit; no form reads the sign-mode control bits.
   always_comb begin
      a_sgn = dec.base_signed;
      b_sgn = dec.use_lit ? 1'b0 : dec.src_signed;
      frac = dec.is_acc & ctrl_q[mul_pkg::CTRL_FRAC_BIT];
   end

   mul_signed_core u_core (
      .op_a(wreg_q[dec.base_idx]),
      .op_b(opb_q),
      .a_signed(a_sgn),
      .b_signed(b_sgn),
      .frac(frac),
      .product(product)
   );

   // Sequencer, register file and APB slave.
   always_comb begin
      state_d = state_q;
      instr_d = instr_q;
      ctrl_d = ctrl_q;
      opb_d = opb_q;
      acc_a_d = acc_a_q;
      acc_b_d = acc_b_q;
      mem_addr_d = mem_addr_q;
      mem_rd_d = 1'b0;
      prdata_d = prdata_q;
      pready_d = 1'b0;
      pslverr_d = 1'b0;
      bus_wr_en = 1'b0;
      ptr_wr_en = 1'b0;
      prod_wr_en = 1'b0;
      if (setup) begin
         pready_d = 1'b1;
         prdata_d = '0;
         if (paddr >= mul_pkg::OFS_WREG_BASE && paddr < mul_pkg::OFS_MEM_DATA) begin
            prdata_d = {16'h0000, wreg_q[paddr[5:2]]};
         end else begin
            case (paddr)
               mul_pkg::OFS_INSTR: prdata_d = {8'h00, instr_q};
               mul_pkg::OFS_CORE_CTRL: prdata_d = {29'h0, ctrl_q};
               mul_pkg::OFS_STATUS: prdata_d = {15'h0, state_q != S_IDLE, flags_q};
               mul_pkg::OFS_ACC_LO_A: prdata_d = acc_a_q[31:0];
               mul_pkg::OFS_ACC_HI_A: prdata_d = {24'h0, acc_a_q[39:32]};
               mul_pkg::OFS_ACC_LO_B: prdata_d = acc_b_q[31:0];
               mul_pkg::OFS_ACC_HI_B: prdata_d = {24'h0, acc_b_q[39:32]};
               mul_pkg::OFS_MEM_DATA: prdata_d = '0;
               default: pslverr_d = 1'b1;
            endcase
         end
         if (pwrite && state_q != S_IDLE &&
             (paddr == mul_pkg::OFS_INSTR || paddr >= mul_pkg::OFS_WREG_BASE)) begin
            pslverr_d = 1'b1;
         end
      end
      if (wr_acc && !pslverr_q) begin
         if (paddr >= mul_pkg::OFS_WREG_BASE && paddr < mul_pkg::OFS_MEM_DATA) begin
            bus_wr_en = 1'b1;
         end else if (paddr == mul_pkg::OFS_CORE_CTRL) begin
            ctrl_d = pwdata[2:0];
         end else if (paddr == mul_pkg::OFS_INSTR) begin
            instr_d = pwdata[23:0];
            state_d = S_FETCH;
         end
      end
      case (state_q)
         S_IDLE: begin
         end
         S_FETCH: begin
            if (!dec.legal) begin
               state_d = S_IDLE;
            end else if (dec.use_lit) begin
               opb_d = {11'h000, dec.lit};
               state_d = S_EXEC;
            end else if (dec.mode == mul_pkg::AM_DIRECT) begin
               opb_d = wreg_q[dec.src_idx];
               state_d = S_EXEC;
            end else begin
               mem_addr_d = (dec.mode == mul_pkg::AM_PREDEC ||
                             dec.mode == mul_pkg::AM_PREINC) ? ptr_new : ptr;
               mem_rd_d = 1'b1;
               state_d = S_WAIT;
               if (dec.mode != mul_pkg::AM_IND) begin
                  ptr_wr_en = 1'b1;
               end
            end
         end
         S_WAIT: begin
            // Peripheral-space reads stretch one cycle before data is used.
            if (mem_addr_q < PERIPH_LIMIT && mem_rd_q) begin
               state_d = S_WAIT;
            end else begin
               opb_d = mem_rdata;
               state_d = S_EXEC;
            end
         end
         S_EXEC: begin
            if (dec.is_acc) begin
               if (dec.acc_sel) begin
                  acc_b_d = {{8{product[31]}}, product};
               end else begin
                  acc_a_d = {{8{product[31]}}, product};
               end
            end else begin
               prod_wr_en = 1'b1;
            end
            state_d = S_IDLE;
         end
         default: state_d = S_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= S_IDLE;
         instr_q <= '0;
         ctrl_q <= mul_pkg::CTRL_RESET;
         flags_q <= mul_pkg::FLAGS_RESET;
         opb_q <= '0;
         acc_a_q <= '0;
         acc_b_q <= '0;
         mem_addr_q <= '0;
         mem_rd_q <= 1'b0;
         prdata_q <= '0;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         state_q <= state_d;
         instr_q <= instr_d;
         ctrl_q <= ctrl_d;
         flags_q <= flags_q;
         opb_q <= opb_d;
         acc_a_q <= acc_a_d;
         acc_b_q <= acc_b_d;
         mem_addr_q <= mem_addr_d;
         mem_rd_q <= mem_rd_d;
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
      end
   end

   // Refuse a build whose constants the decode, register file or peripheral wait logic cannot serve.
   if (mul_pkg::NREG != (1 << mul_pkg::REG_IDX_W)) begin : g_bad_nreg
      $error("register count must match the register index width");
   end
   if (mul_pkg::LIT_W > mul_pkg::DATA_W) begin : g_bad_lit
      $error("short literal wider than an operand");
   end
   if (PERIPH_LIMIT[0] != 1'b0) begin : g_bad_limit
      $error("peripheral limit must be word aligned");
   end

   // Working registers. Bus writes are refused while busy, so they never meet
   // a pointer update or a product write in the same cycle.
   for (genvar g = 0; g < mul_pkg::NREG; g++) begin : g_wreg
      always_comb begin
         wreg_d[g] = wreg_q[g];
         if (bus_wr_en && paddr[5:2] == 4'(g)) begin
            wreg_d[g] = pwdata[15:0];
         end
         if (ptr_wr_en && dec.src_idx == 4'(g)) begin
            wreg_d[g] = ptr_new;
         end
         if (prod_wr_en && dec.dst_idx[3:1] == 3'(g / 2)) begin
            wreg_d[g] = (g % 2 == 0) ? product[15:0] : product[31:16];
         end
      end

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            wreg_q[g] <= '0;
         end else begin
            wreg_q[g] <= wreg_d[g];
         end
      end
   end
endmodule

// File: sim/mul_mem_model.sv
// Purpose: Data memory partner that answers operand reads of the multiplier.
// Assumes: Data is used in the read pulse cycle or up to HOLD cycles later.
// Notes: Outside that span the data lines show the inverse of the last word.
`timescale 1ns/10ps
module mul_mem_model #(
   parameter int HOLD = 2
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Read port
   input wire logic [15:0] mem_addr,
   input wire logic mem_rd,
   output logic [15:0] mem_rdata
);
   logic [15:0] addr_q;
   logic [1:0] hold_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_q <= 16'h0000;
         hold_q <= 2'h0;
      end else if (mem_rd) begin
         addr_q <= mem_addr;
         hold_q <= 2'(HOLD);
      end else if (hold_q != 2'h0) begin
         hold_q <= hold_q - 2'h1;
      end
   end
   // Each word holds a fixed pattern of its own address.
   always_comb begin
      if (mem_rd) mem_rdata = mem_addr ^ 16'h5A3C;
      else if (hold_q != 2'h0) mem_rdata = addr_q ^ 16'h5A3C;
      else mem_rdata = ~(addr_q ^ 16'h5A3C);
   end
endmodule

// File: sim/mixed_sign_multiplier_asserts.sv
// Purpose: Port-level checks of the multiplier.
// Assumes: One clock domain, reset active low.
// Notes: Sees only the top module ports.
`timescale 1ns/10ps
module mixed_sign_multiplier_asserts (
   // APB
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Memory
   input wire logic [15:0] mem_addr,
   input wire logic mem_rd,
   input wire logic [15:0] mem_rdata
);
   default clocking dc @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   logic ins_wr;
   logic ind_mode;
   assign ins_wr = psel && penable && pready && pwrite && !pslverr &&
      paddr == mul_pkg::OFS_INSTR && pwdata[23:17] == 7'h5C;
   assign ind_mode = pwdata[6:4] != 3'h0 && pwdata[6:5] != 2'h3;
   a_ready_after_setup: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   a_unmapped_err: assert property (psel && !penable && paddr == 8'h1C |=> pslverr)
      else $error("unmapped access not refused");
   a_memrd_pulse: assert property (mem_rd |=> !mem_rd)
      else $error("read pulse too long");
   a_addr_held: assert property (mem_rd |=> $stable(mem_addr))
      else $error("address moved during read");
   a_ind_fetch: assert property (ins_wr && ind_mode |-> ##[1:4] mem_rd)
      else $error("indirect operand not fetched");
   a_direct_quiet: assert property (ins_wr && !ind_mode |=> !mem_rd [*4])
      else $error("memory read on direct form");
   cover property (ins_wr && ind_mode);
   cover property (ins_wr && pwdata[10:8] == 3'h7);
   cover property (pslverr);
endmodule

// File: sim/mixed_sign_multiplier_tb.sv
// Purpose: Self-checking bench of the multiplier over APB.
// Assumes: Word and accumulator high reads are zero-extended.
// Notes: The monitor compares each finished transfer with the oldest note.
`timescale 1ns/10ps
module mixed_sign_multiplier_tb;
   typedef struct packed {
      logic chk;
      logic err;
      logic [31:0] dat;
   } note_s;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, mem_rd;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [15:0] mem_addr, mem_rdata;
   int err_count = 0;
   int tests_run = 0;
   note_s notes[$];
   note_s n;
   mixed_sign_multiplier dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_addr(mem_addr),
      .mem_rd(mem_rd), .mem_rdata(mem_rdata));
   mul_mem_model mem_u (.pclk(pclk), .presetn(presetn), .mem_addr(mem_addr),
      .mem_rd(mem_rd), .mem_rdata(mem_rdata));
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %0t read %h expected %h", $time, got, exp);
      end
   endtask
   task automatic check_err(input logic got, input logic exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %0t error flag %b", $time, got);
      end
   endtask
   function automatic logic [7:0] wr_a(input logic [3:0] r);
      return mul_pkg::OFS_WREG_BASE + {2'b00, r, 2'b00};
   endfunction
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
         input logic chk, output logic [31:0] q);
      @(posedge pclk);
      notes.push_back('{chk, a == 8'h1C, d});
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && notes.size() > 0) begin
         n = notes.pop_front();
         check_err(pslverr, n.err);
         if (n.chk) check_word(prdata, n.dat);
      end
   end
   task automatic run_one(input int i);
      logic [31:0] q, ins, pr;
      logic [15:0] a, b, p, m, w, pn;
      logic [3:0] base_r, src_r, dst_r;
      logic [2:0] md;
      logic [4:0] lit;
      logic acc, asel, frac, ss;
      logic [39:0] av;
      int k, kind;
      md = 3'(i % 7);
      kind = (md == 3'h6) ? 0 : i % 3;
      acc = (i / 21) % 2 == 1;
      asel = 1'($urandom);
      frac = 1'($urandom);
      a = 16'($urandom);
      b = 16'($urandom);
      lit = 5'($urandom);
      p = {($urandom_range(1) == 1) ? 4'h0 : 4'h3, 11'($urandom), 1'b0};
      base_r = 4'(1 + 2 * $urandom_range(2));
      src_r = 4'(6 + $urandom_range(1));
      dst_r = 4'(8 + 2 * $urandom_range(2));
      ss = kind != 0;
      m = (md == 3'h4) ? p - 16'h2 : (md == 3'h5) ? p + 16'h2 : p;
      w = (md == 3'h0) ? b : (md == 3'h6) ? {11'h0, lit} : m ^ 16'h5A3C;
      pn = (md == 3'h0) ? b : (md == 3'h2) ? p - 16'h2 : (md == 3'h3) ? p + 16'h2 : m;
      pr = 32'((kind == 2 ? longint'(a) : longint'($signed(a))) *
         (ss ? longint'($signed(w)) : longint'(w)));
      if (acc && frac) pr = pr << 1;
      av = {{8{pr[31]}}, pr};
      ins = {8'h00, (kind == 2) ? 8'hB8 : 8'hB9, ss, base_r, acc ? {3'h7, asel} : dst_r,
         (md == 3'h6) ? {2'h3, lit} : {md, src_r}};
      xfer(1'b1, mul_pkg::OFS_CORE_CTRL, {31'h0, frac}, 1'b0, q);
      xfer(1'b1, wr_a(base_r), {16'h0, a}, 1'b0, q);
      xfer(1'b1, wr_a(src_r), {16'h0, (md == 3'h0) ? b : p}, 1'b0, q);
      xfer(1'b1, mul_pkg::OFS_INSTR, ins, 1'b0, q);
      k = 0;
      do begin
         xfer(1'b0, mul_pkg::OFS_STATUS, 32'h0, 1'b0, q);
         k++;
      end while (q[16] !== 1'b0 && k < 20);
      xfer(1'b0, mul_pkg::OFS_STATUS, 32'h0, 1'b1, q);
      if (acc) begin
         xfer(1'b0, asel ? 8'h14 : 8'h0C, av[31:0], 1'b1, q);
         xfer(1'b0, asel ? 8'h18 : 8'h10, {24'h0, av[39:32]}, 1'b1, q);
      end else begin
         xfer(1'b0, wr_a(dst_r), {16'h0, pr[15:0]}, 1'b1, q);
         xfer(1'b0, wr_a(dst_r + 4'h1), {16'h0, pr[31:16]}, 1'b1, q);
      end
      xfer(1'b0, wr_a(base_r), {16'h0, a}, 1'b1, q);
      xfer(1'b0, wr_a(src_r), {16'h0, pn}, 1'b1, q);
      $display("test %0d done", i);
   endtask
   initial begin
      logic [31:0] q;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      void'($urandom(13));
      xfer(1'b0, mul_pkg::OFS_CORE_CTRL, 32'h0, 1'b1, q);
      xfer(1'b0, mul_pkg::OFS_STATUS, 32'h0, 1'b1, q);
      xfer(1'b0, 8'h1C, 32'h0, 1'b0, q);
      $display("test reset done");
      for (int i = 0; i < 42; i++) run_one(i);
      tally_and_finish();
   end
   initial begin
      repeat (20000) @(posedge pclk);
      err_count++;
      tally_and_finish();
   end
endmodule
bind mixed_sign_multiplier mixed_sign_multiplier_asserts chk_u (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata));
